/* verilog/bps_map.svh */
// Register offsets, command codes and field positions for the buffered program host controller
`ifndef BPS_MAP_SVH
`define BPS_MAP_SVH
// Wishbone register word offsets (byte address bits [4:2])
`define BPS_REG_CTRL      3'h0
`define BPS_REG_ADDR      3'h1
`define BPS_REG_COUNT     3'h2
`define BPS_REG_STATUS    3'h3
`define BPS_REG_POLL      3'h4
`define BPS_REG_BUF       3'h5
// Control register command field
`define BPS_OP_NONE       3'h0
`define BPS_OP_PROGRAM    3'h1
`define BPS_OP_SUSPEND    3'h2
`define BPS_OP_RESUME     3'h3
`define BPS_OP_ABORT_RST  3'h4
`define BPS_OP_READ       3'h5
// Control register bit positions
`define BPS_CTRL_BYPASS   3
`define BPS_CTRL_HV       4
// Device command codes
`define BPS_CMD_UNLOCK1   16'h00AA
`define BPS_CMD_UNLOCK2   16'h0055
`define BPS_CMD_SETUP     16'h0025
`define BPS_CMD_CONFIRM   16'h0029
`define BPS_CMD_ABORT_RST 16'h00F0
`define BPS_CMD_SUSPEND   16'h00B0
`define BPS_CMD_RESUME    16'h0030
// Unlock addresses
`define BPS_ADDR_UNLOCK1  26'h000_0555
`define BPS_ADDR_UNLOCK2  26'h000_02AA
// Buffer sizing
`define BPS_BUF_WORDS     512
`define BPS_MAX_COUNT     9'h1FF
`define BPS_PAGE_LSB      9
`define BPS_BLOCK_LSB     16
// Polling bit positions
`define BPS_POLL_ABORT    1
`define BPS_POLL_ERROR    5
`define BPS_POLL_TOGGLE   6
`define BPS_POLL_POLARITY 7
// Bus cycle phase timer load; a phase lasts this many clocks plus one (5 ns each)
`define BPS_PHASE_CYC     4'h4
`endif

/* verilog/bps_pkg.sv */
// Types shared by the buffered program host controller modules
`default_nettype none
package bps_pkg;
  typedef logic [25:0] bps_addr_t;
  typedef logic [15:0] bps_data_t;
  typedef enum logic [3:0] {
    BPS_IDLE    = 4'b0000,
    BPS_UNL1    = 4'b0001,
    BPS_UNL2    = 4'b0010,
    BPS_SETUP   = 4'b0011,
    BPS_COUNT   = 4'b0100,
    BPS_LOAD    = 4'b0101,
    BPS_CONFIRM = 4'b0110,
    BPS_SINGLE  = 4'b0111,
    BPS_POLL    = 4'b1000,
    BPS_DONE    = 4'b1001,
    BPS_ARST1   = 4'b1010,
    BPS_ARST2   = 4'b1011,
    BPS_ARST3   = 4'b1100
  } bps_state_t;
  typedef enum logic [2:0] {
    BPS_CYC_IDLE  = 3'b000,
    BPS_CYC_SET   = 3'b001,
    BPS_CYC_PULSE = 3'b010,
    BPS_CYC_HOLD  = 3'b011,
    BPS_CYC_END   = 3'b100
  } bps_cyc_t;
endpackage
`default_nettype wire

/* verilog/bps_cyc_if.sv */
// Interface between the sequencer and the flash bus cycle engine
`timescale 1ns/100ps
`default_nettype none
interface bps_cyc_if;
  import bps_pkg::*;
  logic      req;   // Start one bus cycle
  logic      wr;    // One for write, zero for read
  bps_addr_t addr;  // Cycle address
  bps_data_t wdata; // Write data
  logic      done;  // Cycle finished pulse
  bps_data_t rdata; // Read data captured at end
  modport seq (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface
`default_nettype wire

/* verilog/bps_cyc_engine.sv */
// Flash bus cycle engine: one asynchronous read or write strobe per request
`timescale 1ns/100ps
`default_nettype none
`include "bps_map.svh"
module bps_cyc_engine (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  bps_cyc_if.eng               cyc,
  output logic [25:0]          fl_addr_o,
  output logic [15:0]          fl_dq_o,
  output logic                 fl_dq_oe_n_o,
  input  wire logic [15:0]     fl_dq_i,
  output logic                 fl_ce_n_o,
  output logic                 fl_we_n_o,
  output logic                 fl_oe_n_o
);
  import bps_pkg::*;
  // ****************************************
  // Phase state
  // ****************************************
  bps_cyc_t    st;        // Current phase
  bps_cyc_t    next_st;
  logic [3:0]  cnt;       // Phase timer
  logic [3:0]  next_cnt;
  logic        wr;        // Latched direction
  logic        next_wr;
  logic [15:0] rdata;     // Captured read data
  logic [15:0] next_rdata;
  logic [25:0] addr;      // Latched address
  logic [25:0] next_addr;
  logic [15:0] wdata;     // Latched write data
  logic [15:0] next_wdata;
  // Next phase computation
  always_comb begin
    next_st    = st;
    next_cnt   = cnt;
    next_wr    = wr;
    next_rdata = rdata;
    next_addr  = addr;
    next_wdata = wdata;
    case (st)
      BPS_CYC_IDLE: begin
        if (cyc.req) begin
          next_st    = BPS_CYC_SET;
          next_wr    = cyc.wr;
          next_addr  = cyc.addr;
          next_wdata = cyc.wdata;
          next_cnt   = `BPS_PHASE_CYC;
        end
      end
      BPS_CYC_SET, BPS_CYC_PULSE, BPS_CYC_HOLD: begin
        if (cnt == 4'h0) begin
          next_cnt = `BPS_PHASE_CYC;
          // Capture read data just before the strobe rises
          if (st == BPS_CYC_PULSE && !wr) begin
            next_rdata = fl_dq_i;
          end
          next_st = (st == BPS_CYC_SET)   ? BPS_CYC_PULSE :
                    (st == BPS_CYC_PULSE) ? BPS_CYC_HOLD  : BPS_CYC_END;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      BPS_CYC_END: next_st = BPS_CYC_IDLE;
      default:     next_st = BPS_CYC_IDLE;
    endcase
  end
  // Phase registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st    <= BPS_CYC_IDLE;
      cnt   <= 4'h0;
      wr    <= 1'b0;
      rdata <= 16'h0000;
      addr  <= 26'h000_0000;
      wdata <= 16'h0000;
    end else begin
      st    <= next_st;
      cnt   <= next_cnt;
      wr    <= next_wr;
      rdata <= next_rdata;
      addr  <= next_addr;
      wdata <= next_wdata;
    end
  end
  // ****************************************
  // Pin drive
  // ****************************************
  assign fl_addr_o    = addr;
  assign fl_dq_o      = wdata;
  assign fl_dq_oe_n_o = !(wr && st != BPS_CYC_IDLE);
  assign fl_ce_n_o    = (st == BPS_CYC_IDLE) || (st == BPS_CYC_END);
  assign fl_we_n_o    = !(wr && st == BPS_CYC_PULSE);
  assign fl_oe_n_o    = !(!wr && st == BPS_CYC_PULSE);
  assign cyc.done     = (st == BPS_CYC_END);
  assign cyc.rdata    = rdata;
endmodule
`default_nettype wire

/* verilog/bps_host.sv */
// Buffered program host controller: Wishbone registers, page buffer and flash command sequencer
// Summary of operation
// - Two unlocks then setup in block
// - Count n to block; n+1 words
// - First pair, then n more loads
// - Page-aligned start recommended for speed
// - Confirm 29h programs loaded entries
// - Abort needs three-cycle F0h reset
// - Bypass mode omits two unlock writes
`timescale 1ns/100ps
`default_nettype none
`include "bps_map.svh"
module bps_host (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [31:0]        wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  input  wire logic [3:0]         wb_sel_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  output logic [25:0]             fl_addr_o,
  output logic [15:0]             fl_dq_o,
  output logic                    fl_dq_oe_n_o,
  input  wire logic [15:0]        fl_dq_i,
  output logic                    fl_ce_n_o,
  output logic                    fl_we_n_o,
  output logic                    fl_oe_n_o,
  output logic                    fl_hv_en_o
);
  import bps_pkg::*;
  // ****************************************
  // Shared state
  // ****************************************
  bps_cyc_if   cyc ();                        // Bus cycle carrier
  bps_state_t  st;                            // Sequencer state
  bps_state_t  next_st;
  logic [9:0]  idx;                           // Load index
  logic [9:0]  next_idx;
  logic [8:0]  count;                         // Count n from software
  logic        bypass;                        // Bypass mode selected
  logic        hv;                            // Drive high voltage on protect
  bps_addr_t   base;                          // Start address
  logic        busy;                          // Operation in progress
  logic        abort;                         // Sticky device abort seen
  logic        next_abort;
  logic        fail;                          // Sticky device error seen
  logic        next_fail;
  logic        done;                          // Sticky finished
  logic        next_done;
  logic [15:0] poll;                          // Last polling word read
  logic [15:0] next_poll;
  logic [15:0] prev_poll;                     // Polling word before it
  logic [15:0] next_prev_poll;
  logic [2:0]  op;                            // Pending single command
  logic [2:0]  next_op;
  logic [15:0] buf_mem [0:`BPS_BUF_WORDS-1];  // Page buffer data
  logic [15:0] buf_rd;                        // Buffer word at index
  logic        ack;                           // Wishbone ack register
  logic        wr_hit;                        // Wishbone write strobe
  logic [2:0]  reg_sel;                       // Word offset
  // ****************************************
  // Wishbone slave
  // ****************************************
  assign reg_sel = wb_adr_i[4:2];
  // A write lands on the same edge at which the master sees ack high
  assign wr_hit  = wb_cyc_i && wb_stb_i && wb_we_i && ack;
  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= wb_cyc_i && wb_stb_i && !ack;
    end
  end
  assign wb_ack_o = ack;
  // Config registers, written only while idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count  <= 9'h000;
      bypass <= 1'b0;
      hv     <= 1'b0;
      base   <= 26'h000_0000;
    end else if (wr_hit && !busy && wb_sel_i[0]) begin
      case (reg_sel)
        `BPS_REG_CTRL: begin
          bypass <= wb_dat_i[`BPS_CTRL_BYPASS];
          hv     <= wb_dat_i[`BPS_CTRL_HV];
        end
        `BPS_REG_ADDR:  base  <= wb_dat_i[25:0];
        `BPS_REG_COUNT: count <= wb_dat_i[8:0];
        default: ;
      endcase
    end
  end
  // Buffer write at base-relative word offset; later writes replace earlier
  always_ff @(posedge clk_i) begin
    if (wr_hit && !busy && reg_sel == `BPS_REG_BUF) begin
      buf_mem[wb_dat_i[24:16]] <= wb_dat_i[15:0];
    end
  end
  assign buf_rd = buf_mem[idx[8:0]];
  // Read mux; unmapped offsets read zero
  always_comb begin
    case (reg_sel)
      `BPS_REG_CTRL:   wb_dat_o = {27'h0, hv, bypass, op};
      `BPS_REG_ADDR:   wb_dat_o = {6'h00, base};
      `BPS_REG_COUNT:  wb_dat_o = {23'h0, count};
      `BPS_REG_STATUS: wb_dat_o = {27'h0, st == BPS_IDLE ? 1'b0 : 1'b1, 1'b0, fail, abort, done};
      `BPS_REG_POLL:   wb_dat_o = {prev_poll, poll};
      default:         wb_dat_o = 32'h0000_0000;
    endcase
  end
  assign busy       = (st != BPS_IDLE);
  assign fl_hv_en_o = hv;
  // ****************************************
  // Command sequencer
  // ****************************************
  // Next state, bus request and status
  always_comb begin
    next_st        = st;
    next_idx       = idx;
    next_abort     = abort;
    next_fail      = fail;
    next_done      = done;
    next_poll      = poll;
    next_prev_poll = prev_poll;
    next_op        = op;
    cyc.req        = 1'b0;
    cyc.wr         = 1'b1;
    cyc.addr       = base;
    cyc.wdata      = 16'h0000;
    case (st)
      BPS_IDLE: begin
        if (wr_hit && reg_sel == `BPS_REG_CTRL && wb_sel_i[0]) begin
          next_op   = wb_dat_i[2:0];
          next_done = 1'b0;
          case (wb_dat_i[2:0])
            // Bypass or high voltage skips the unlock pair
            `BPS_OP_PROGRAM: begin
              next_abort = 1'b0;
              next_fail  = 1'b0;
              next_st = (wb_dat_i[`BPS_CTRL_BYPASS] || wb_dat_i[`BPS_CTRL_HV]) ? BPS_SETUP : BPS_UNL1;
            end
            `BPS_OP_ABORT_RST:                    next_st = BPS_ARST1;
            `BPS_OP_SUSPEND, `BPS_OP_RESUME,
            `BPS_OP_READ:                         next_st = BPS_SINGLE;
            default: ;
          endcase
        end
      end
      BPS_UNL1: begin
        cyc.req   = 1'b1;
        cyc.addr  = `BPS_ADDR_UNLOCK1;
        cyc.wdata = `BPS_CMD_UNLOCK1;
        if (cyc.done) next_st = BPS_UNL2;
      end
      BPS_UNL2: begin
        cyc.req   = 1'b1;
        cyc.addr  = `BPS_ADDR_UNLOCK2;
        cyc.wdata = `BPS_CMD_UNLOCK2;
        if (cyc.done) next_st = BPS_SETUP;
      end
      BPS_SETUP: begin
        cyc.req   = 1'b1;
        cyc.wdata = `BPS_CMD_SETUP;
        if (cyc.done) next_st = BPS_COUNT;
      end
      BPS_COUNT: begin
        cyc.req   = 1'b1;
        cyc.wdata = {7'h00, count};
        next_idx  = 10'h000;
        if (cyc.done) next_st = BPS_LOAD;
      end
      BPS_LOAD: begin
        // Offsets stay inside base page, so block and page never cross
        cyc.req   = 1'b1;
        cyc.addr  = {base[25:`BPS_PAGE_LSB], base[8:0] | idx[8:0]};
        cyc.wdata = buf_rd;
        if (cyc.done) begin
          next_idx = idx + 10'h001;
          if (idx[8:0] == count) next_st = BPS_CONFIRM;
        end
      end
      BPS_CONFIRM: begin
        cyc.req   = 1'b1;
        cyc.wdata = `BPS_CMD_CONFIRM;
        if (cyc.done) next_st = BPS_POLL;
      end
      BPS_SINGLE: begin
        cyc.req   = 1'b1;
        cyc.wr    = (op != `BPS_OP_READ);
        cyc.wdata = (op == `BPS_OP_SUSPEND) ? `BPS_CMD_SUSPEND : `BPS_CMD_RESUME;
        if (cyc.done) begin
          next_poll = cyc.rdata;
          next_done = 1'b1;
          next_st   = BPS_IDLE;
        end
      end
      BPS_POLL: begin
        // Two polling reads; toggle bit steady means finished
        // A flag counts only in two reads in a row, so the first array read is not mistaken for one
        cyc.req = 1'b1;
        cyc.wr  = 1'b0;
        if (cyc.done) begin
          next_prev_poll = poll;
          next_poll      = cyc.rdata;
          next_idx       = idx + 10'h001;
          if (idx != 10'h000 &&
              cyc.rdata[`BPS_POLL_TOGGLE] == poll[`BPS_POLL_TOGGLE]) begin
            next_done = 1'b1;
            next_st   = BPS_IDLE;
          end else if (idx != 10'h000 && cyc.rdata[`BPS_POLL_ABORT] && poll[`BPS_POLL_ABORT]) begin
            next_abort = 1'b1;
            next_st    = BPS_IDLE;
          end else if (idx != 10'h000 && cyc.rdata[`BPS_POLL_ERROR] && poll[`BPS_POLL_ERROR]) begin
            next_fail = 1'b1;
            next_st   = BPS_IDLE;
          end
        end
      end
      BPS_ARST1: begin
        cyc.req   = 1'b1;
        cyc.addr  = `BPS_ADDR_UNLOCK1;
        cyc.wdata = `BPS_CMD_UNLOCK1;
        if (cyc.done) next_st = BPS_ARST2;
      end
      BPS_ARST2: begin
        cyc.req   = 1'b1;
        cyc.addr  = `BPS_ADDR_UNLOCK2;
        cyc.wdata = `BPS_CMD_UNLOCK2;
        if (cyc.done) next_st = BPS_ARST3;
      end
      BPS_ARST3: begin
        cyc.req   = 1'b1;
        cyc.addr  = `BPS_ADDR_UNLOCK1;
        cyc.wdata = `BPS_CMD_ABORT_RST;
        if (cyc.done) begin
          next_abort = 1'b0;
          next_done  = 1'b1;
          next_st    = BPS_IDLE;
        end
      end
      default: next_st = BPS_IDLE;
    endcase
    // Entering polling restarts the index
    if (st == BPS_CONFIRM && cyc.done) next_idx = 10'h000;
  end
  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st        <= BPS_IDLE;
      idx       <= 10'h000;
      abort     <= 1'b0;
      fail      <= 1'b0;
      done      <= 1'b0;
      poll      <= 16'h0000;
      prev_poll <= 16'h0000;
      op        <= `BPS_OP_NONE;
    end else begin
      st        <= next_st;
      idx       <= next_idx;
      abort     <= next_abort;
      fail      <= next_fail;
      done      <= next_done;
      poll      <= next_poll;
      prev_poll <= next_prev_poll;
      op        <= next_op;
    end
  end
  // ****************************************
  // Flash bus cycle engine
  // ****************************************
  bps_cyc_engine u_eng (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .cyc          (cyc.eng),
    .fl_addr_o    (fl_addr_o),
    .fl_dq_o      (fl_dq_o),
    .fl_dq_oe_n_o (fl_dq_oe_n_o),
    .fl_dq_i      (fl_dq_i),
    .fl_ce_n_o    (fl_ce_n_o),
    .fl_we_n_o    (fl_we_n_o),
    .fl_oe_n_o    (fl_oe_n_o)
  );
endmodule
`default_nettype wire

/* tb/bps_host_chk.sv */
// Concurrent checks on the buffered program host ports
`timescale 1ns/100ps
`default_nettype none
module bps_host_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [25:0] fl_addr_o,
  input wire logic [15:0] fl_dq_o,
  input wire logic        fl_dq_oe_n_o,
  input wire logic        fl_ce_n_o,
  input wire logic        fl_we_n_o,
  input wire logic        fl_oe_n_o
);
  // **********
  // Bus answer and flash strobe timing
  // **********
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Every request is answered on the next edge, for one cycle only
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  // Reset leaves every strobe idle
  property p_reset_idle; $fell(rst_i) |-> fl_ce_n_o && fl_we_n_o && fl_oe_n_o && !wb_ack_o; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("strobe after reset");
  // A write strobe sits inside a selected cycle with the host on the data bus
  property p_we_in_ce; !fl_we_n_o |-> !fl_ce_n_o && !fl_dq_oe_n_o && fl_oe_n_o; endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("write outside cycle");
  // A read strobe finds the host off the data bus
  property p_oe_free; !fl_oe_n_o |-> !fl_ce_n_o && fl_dq_oe_n_o; endproperty
  a_oe_free: assert property (p_oe_free) else $error("bus clash on read");
  // Write pulse lasts five clocks with address and data held
  property p_we_width; $fell(fl_we_n_o) |-> !fl_we_n_o[*5] ##1 fl_we_n_o; endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse width");
  property p_we_data; $fell(fl_we_n_o) |=> ($stable(fl_addr_o) && $stable(fl_dq_o))[*4]; endproperty
  a_we_data: assert property (p_we_data) else $error("write data moved");
  // Chip select leads the write pulse by the setup phase
  property p_we_setup; $fell(fl_we_n_o) |-> $past(fl_ce_n_o, 4) == 1'b0 && $stable(fl_addr_o); endproperty
  a_we_setup: assert property (p_we_setup) else $error("write setup short");
  // Hold phase keeps select, bus and address, then select rises
  property p_we_hold;
    $rose(fl_we_n_o) |-> (!fl_ce_n_o && !fl_dq_oe_n_o && $stable(fl_addr_o))[*5] ##1 fl_ce_n_o;
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("write hold short");
  // Read pulse lasts five clocks
  property p_oe_width; $fell(fl_oe_n_o) |-> !fl_oe_n_o[*5] ##1 fl_oe_n_o; endproperty
  a_oe_width: assert property (p_oe_width) else $error("read pulse width");
endmodule
bind bps_host bps_host_chk bps_host_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o),
  .fl_dq_oe_n_o(fl_dq_oe_n_o), .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o));
`default_nettype wire

/* tb/bps_flash_model.sv */
// Behavioural flash device answering the buffered program host
`timescale 1ns/100ps
`default_nettype none
module bps_flash_model (
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [25:0] addr_i,
  input  wire logic [15:0] host_dq_i,
  input  wire logic        host_oe_n_i,
  input  wire logic        hv_i,
  input  wire logic        byp_i,
  input  wire logic        abort_i,
  input  wire logic        slow_i,
  output logic [15:0]      dq_o,
  output logic             idle_o,
  output logic [7:0]       bad_o,
  output logic [9:0]       nld_o
);
  // **********
  // Command decode and polling register
  // **********
  logic [15:0] mem [512]; // Page array of 512 words
  logic [15:0] word;      // Word last driven on a read
  logic [15:0] last;      // Data of the last load
  logic [15:0] cmd;       // Last suspend or resume code seen
  logic [9:0]  blk;       // Block named at setup
  logic [16:0] page;      // Page of the first load
  logic [9:0]  cnt;       // Loads still owed
  logic        tog;       // Toggle bit state
  int          st;        // Command state
  int          left;      // Polling reads until done
  // Wire level: host while it drives, else the device, else the inverse of its last word
  assign dq_o   = !host_oe_n_i ? host_dq_i : (!oe_n_i && !ce_n_i) ? word : ~word;
  assign idle_o = (st == 0);
  initial begin
    st = 0;
    bad_o = 8'h00;
    nld_o = 10'h000;
    tog = 1'b0;
    word = 16'h0000;
    last = 16'h0000;
    cmd = 16'h0000;
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  // Writes are taken on the rising write strobe of a selected cycle
  always @(posedge we_n_i) begin
    if (!ce_n_i) begin
      case (st)
        0: begin
          blk = addr_i[25:16];
          if (dq_o == 16'h00AA && addr_i == 26'h000_0555) st = 1;
          else if ((hv_i || byp_i) && dq_o == 16'h0025) st = 3;
          else if (dq_o == 16'h00B0 || dq_o == 16'h0030) cmd = dq_o;
          else bad_o++;
        end
        1: if (dq_o == 16'h0055 && addr_i == 26'h000_02AA) st = 2; else bad_o++;
        2: begin
          blk = addr_i[25:16];
          if (dq_o == 16'h0025) st = 3; else bad_o++;
        end
        3: begin
          cnt = dq_o[9:0];
          nld_o = 10'h000;
          st = (addr_i[25:16] != blk || dq_o > 16'h01FF) ? 7 : 4;
        end
        4: begin
          if (nld_o == 10'h000) page = addr_i[25:9];
          mem[addr_i[8:0]] = dq_o;
          last = dq_o;
          nld_o++;
          if (addr_i[25:16] != blk || addr_i[25:9] != page) st = 7;
          else if (cnt == 10'h000) st = 5;
          cnt--;
        end
        5: st = (dq_o == 16'h0029 && !abort_i) ? 6 : 7;
        7: if (dq_o == 16'h00AA) st = 8; else bad_o++;
        8: st = (dq_o == 16'h0055) ? 9 : 7;
        9: st = (dq_o == 16'h00F0) ? 0 : 7;
        default: bad_o++;
      endcase
      left = slow_i ? 40 : 3;
    end
  end
  // Reads give the polling word while busy or aborted, else the array
  always @(negedge oe_n_i) begin
    if (!ce_n_i && st >= 6) begin
      tog = ~tog;
      word = {8'h00, ~last[7], tog, 4'h0, st != 6, 1'b0};
      left--;
      if (st == 6 && left == 0) st = 0;
    end
    else if (!ce_n_i) word = mem[addr_i[8:0]];
  end
endmodule
`default_nettype wire

/* tb/bps_host_tb_top.sv */
// Self-checking bench for the buffered program host controller
`timescale 1ns/100ps
`default_nettype none
module bps_host_tb_top;
  // **********
  // Signals, drivers and expectations
  // **********
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o;
  logic [31:0] wb_adr, wb_dat, wb_dat_o, q, seed;
  logic [3:0]  wb_sel;
  logic [25:0] fl_addr_o;
  logic [15:0] fl_dq_o, fl_dq_i;
  logic        fl_dq_oe_n_o, fl_ce_n_o, fl_we_n_o, fl_oe_n_o, fl_hv_en_o;
  logic        byp, abt, slow, idle; // Device mode, fault and speed
  logic [7:0]  bad;                  // Sequence faults seen by the device
  logic [9:0]  nld;                  // Loads seen by the device
  logic [15:0] exp_d [512];          // Data loaded per offset
  int          failures, total_checks;
  bps_host bps_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fl_addr_o(fl_addr_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_n_o(fl_dq_oe_n_o),
    .fl_dq_i(fl_dq_i), .fl_ce_n_o(fl_ce_n_o), .fl_we_n_o(fl_we_n_o), .fl_oe_n_o(fl_oe_n_o),
    .fl_hv_en_o(fl_hv_en_o));
  bps_flash_model bps_flash_model_inst (.ce_n_i(fl_ce_n_o), .we_n_i(fl_we_n_o), .oe_n_i(fl_oe_n_o),
    .addr_i(fl_addr_o), .host_dq_i(fl_dq_o), .host_oe_n_i(fl_dq_oe_n_o), .hv_i(fl_hv_en_o),
    .byp_i(byp), .abort_i(abt), .slow_i(slow), .dq_o(fl_dq_i), .idle_o(idle), .bad_o(bad), .nld_o(nld));
  // Clock at 200 MHz
  always #2.5 clk_i = ~clk_i;
  // Xorshift source
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Polling word of an abort, toggle bit masked
  function logic [15:0] abort_word(input logic [15:0] d);
    return {8'h00, ~d[7], 1'b0, 4'h0, 1'b1, 1'b0};
  endfunction
  task end_sim();
    if (failures == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // One classic Wishbone cycle; read data lands in q
  task wb(input logic we, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 20) begin
      failures++;
      end_sim();
    end
  endtask
  // Poll status until busy is clear and every bit of stop is set
  task wait_idle(input logic [31:0] stop);
    int k;
    for (k = 0; k < 8000; k++) begin
      wb(1'b0, 32'h0000_000C, 32'h0);
      if (q[4] === 1'b0 && (q & stop) === stop) break;
    end
    if (k >= 8000) begin
      failures++;
      end_sim();
    end
  endtask
  // Load the buffer at random, then start a program; mode is {hv, bypass}
  task prog(input logic [25:0] base, input logic [8:0] n, input logic [1:0] mode, input logic [31:0] stop);
    int i;
    for (i = 0; i <= n; i++) begin
      exp_d[i] = 16'(rnd());
      wb(1'b1, 32'h0000_0014, {7'h00, 9'(i), exp_d[i]});
    end
    wb(1'b1, 32'h0000_0004, 32'(base));
    wb(1'b1, 32'h0000_0008, 32'(n));
    byp <= mode[0];
    wb(1'b1, 32'h0000_0000, {27'h0, mode, 3'h1});
    wait_idle(stop);
  endtask
  // **********
  // Main sequence
  // **********
  initial begin
    int it, i;
    logic [31:0] r;
    logic [8:0]  n;
    {clk_i, wb_cyc, wb_stb, wb_we, byp, abt, slow} = 7'h00;
    {wb_adr, wb_dat, wb_sel} = {64'h0, 4'hF};
    {failures, total_checks, seed, rst_i} = {32'h0, 32'h0, 32'h0000_E6C4, 1'b1};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 32'h0000_000C, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 32'h0000_001C, 32'h0);
    chk(q, 32'h0);
    for (it = 0; it < 7; it++) begin
      r = rnd();
      n = (it == 0) ? 9'h000 : (it == 1) ? 9'h1FF : 9'(r[31:28]);
      slow <= r[2];
      prog({r[24:8], 9'h000}, n, r[1:0], 32'h1);
      chk(q & 32'h0000_0007, 32'h1);
      chk(32'(fl_hv_en_o), 32'(r[1]));
      chk(32'(nld), 32'(n) + 32'h1);
      chk(32'(bad), 32'h0);
      for (i = 0; i <= n; i++) chk(32'(bps_flash_model_inst.mem[i]), 32'(exp_d[i]));
    end
    abt <= 1'b1;
    prog(26'h001_0200, 9'h003, 2'b01, 32'h2);
    chk(q & 32'h0000_0007, 32'h2);
    wb(1'b0, 32'h0000_0010, 32'h0);
    chk(32'(q[15:0] & 16'hFFBF), 32'(abort_word(exp_d[3])));
    abt <= 1'b0;
    wb(1'b1, 32'h0000_0000, 32'h0000_000C);
    wait_idle(32'h0);
    chk(32'(idle), 32'h1);
    chk(q & 32'h0000_0002, 32'h0);
    wb(1'b1, 32'h0000_0000, 32'h0000_0002);
    wait_idle(32'h1);
    chk(32'(bps_flash_model_inst.cmd), 32'h0000_00B0);
    wb(1'b1, 32'h0000_0000, 32'h0000_0003);
    wait_idle(32'h1);
    chk(32'(bps_flash_model_inst.cmd), 32'h0000_0030);
    wb(1'b1, 32'h0000_0000, 32'h0000_0005);
    wait_idle(32'h1);
    wb(1'b0, 32'h0000_0010, 32'h0);
    chk(32'(q[15:0]), 32'(exp_d[0]));
    end_sim();
  end
endmodule
`default_nettype wire
